// [verilog/mhd_pkg.sv]
package mhd_pkg;
  // speed codes
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // system clock
  localparam int CLK_MHZ = 50;
  // clock-switch settling time for a forced speed change
  localparam int SPD_SWITCH_NS = 1000;
  localparam int SPD_SWITCH_CYC = (SPD_SWITCH_NS * CLK_MHZ + 999) / 1000;
  // link timing in bit times, one byte per link clock
  localparam int BITS_PER_CLK = 8;
  localparam int IFG_BITS = 96;
  localparam int SLOT_BITS = 512;
  localparam int JAM_BITS = 32;
  localparam int IFG_CYC = IFG_BITS / BITS_PER_CLK;
  localparam int SLOT_CYC = SLOT_BITS / BITS_PER_CLK;
  localparam int JAM_CYC = JAM_BITS / BITS_PER_CLK;
  localparam logic [7:0] JAM_BYTE = 8'h55;
  // attempt limit and backoff exponent ceiling
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam logic [4:0] BACKOFF_LIMIT = 5'h0A;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  // packet buffer
  localparam int BUF_AW = 11;
  localparam int BUF_DEPTH = 2048;
  // auto speed detect: system cycles between edges of a link-clock divider bit
  localparam int ASD_DIV_BIT = 3;
  localparam logic [7:0] ASD_FAST_MAX = 8'h08;
  localparam logic [7:0] ASD_MID_MAX = 8'h40;
endpackage

// [verilog/mhd_top.sv]
`timescale 1ns/1ps
// Operation
// R1: half duplex defers while carrier sense asserted
// R2: transmit enable asserted at frame's first cycle
// R3: collision stops data within four clocks, jam
// R4: after collision, back off and retry
// R5: retries replay frame from internal buffer
// R6: next frame only after inter-frame gap
// R7: phy returns carrier within one slot
// R8: no carrier in slot: succeed, count it
// R9: link down until set-link-up is set
// R10: no driver plus autoneg: flow bits from result
// R11: force speed uses software speed field
// R12: bypass applies speed at once, else delayed
// R13: neither forced nor auto: reload speed at link-up
// R14: status speed shows current mac speed
// R15: auto detect speed from phy receive clock
// R16: sample phy duplex at each good link
// R17: force duplex uses select bit, else phy
// R18: link-up status mirrors phy link when enabled
// R19: phy link drop means link down
// R20: link change raises interrupt when enabled
// R21: software forces mac, then phy, then link-up
// R22: manager drops flow advertisement, restarts autoneg
// R23: jam lasts 32 bits before backoff
module mhd_top
  import mhd_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic nrst_in, // async reset, active low
  input wire logic link_clk_in, // phy transmit/receive clock
  input wire logic buf_wr_en_in, // buffer write strobe, link clock
  input wire logic [BUF_AW-1:0] buf_wr_addr_in, // buffer write address
  input wire logic [7:0] buf_wr_data_in, // buffer write byte
  input wire logic [BUF_AW-1:0] tx_len_in, // frame length in bytes
  input wire logic tx_start_in, // send buffered frame, link clock
  output logic tx_ready_out, // transmitter idle
  output logic tx_done_out, // frame sent pulse
  output logic tx_abort_out, // excess collisions pulse
  output logic [7:0] txd_out, // transmit data to phy
  output logic tx_en_out, // transmit enable to phy
  input wire logic crs_in, // phy carrier sense
  input wire logic col_in, // phy collision
  input wire logic phy_link_in, // phy link indication
  input wire logic phy_full_duplex_indication_in, // phy duplex
  input wire logic [1:0] phy_speed_indication_in, // phy speed
  input wire logic an_tx_pause_in, // autoneg tx pause result
  input wire logic an_rx_pause_in, // autoneg rx pause result
  input wire logic set_link_up_in, // software link enable
  input wire logic force_speed_in, // software forces speed
  input wire logic [1:0] speed_select_in, // software speed field
  input wire logic speed_switch_bypass_in, // skip clock switch delay
  input wire logic auto_speed_detect_enable_in, // infer speed from clock
  input wire logic force_duplex_in, // software forces duplex
  input wire logic force_duplex_alt_in, // alternate force duplex
  input wire logic duplex_select_bit_in, // forced duplex value
  input wire logic link_change_int_en_in, // link change interrupt enable
  input wire logic driver_loaded_in, // software driver present
  input wire logic autoneg_enable_in, // autonegotiation enabled
  input wire logic sw_tx_flow_in, // software tx flow control
  input wire logic sw_rx_flow_in, // software rx flow control
  output logic link_up_status_out, // link up status
  output logic [1:0] speed_status_out, // current mac speed
  output logic duplex_status_bit_out, // 1 full duplex
  output logic tx_flow_ctrl_enable_out, // tx flow control enable
  output logic rx_flow_ctrl_enable_out, // rx flow control enable
  output logic link_change_interrupt_out, // link change pulse
  output logic [31:0] tx_no_crs_count_out // transmits without carrier
);

  typedef enum logic [2:0] {ST_IDLE, ST_DEFER, ST_XMIT, ST_JAM, ST_BACKOFF, ST_IFG} mhd_tx_e;

  function automatic logic [9:0] bo_mask(input logic [4:0] n);
    logic [4:0] k;
    k = (n > BACKOFF_LIMIT) ? BACKOFF_LIMIT : n;
    bo_mask = 10'(10'h3FF >> (BACKOFF_LIMIT - k));
  endfunction

  // ---------------- link domain ----------------
  logic [7:0] mem_r [BUF_DEPTH];
  logic [2:0] lsy1_r, lsy2_r;
  logic crs_s, col_s, dup_s;
  logic [15:0] lfsr_r;
  logic [ASD_DIV_BIT:0] div_r;
  mhd_tx_e st_r;
  logic [BUF_AW-1:0] len_r, rd_ptr_r;
  logic [7:0] cnt_r;
  logic [4:0] att_r;
  logic [9:0] bo_slots_r;
  logic crs_seen_r, nocrs_tog_r, tx_en_r, done_r, abort_r;
  logic [7:0] txd_r;
  logic duplex_r;

  always_ff @(posedge link_clk_in)
  begin
    if (buf_wr_en_in)
    begin
      mem_r[buf_wr_addr_in] <= buf_wr_data_in;
    end
  end

  // carrier and collision are asynchronous to the transmit side
  always_ff @(posedge link_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      lsy1_r <= 3'h0;
      lsy2_r <= 3'h0;
    end
    else
    begin
      lsy1_r <= {duplex_r, col_in, crs_in};
      lsy2_r <= lsy1_r;
    end
  end
  assign crs_s = lsy2_r[0];
  assign col_s = lsy2_r[1];
  assign dup_s = lsy2_r[2];

  always_ff @(posedge link_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      lfsr_r <= LFSR_SEED;
      div_r <= '0;
    end
    else
    begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      div_r <= div_r + 1'b1;
    end
  end

  always_ff @(posedge link_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_r <= ST_IDLE;
      len_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= 8'h00;
      att_r <= 5'h00;
      bo_slots_r <= 10'h000;
      crs_seen_r <= 1'b0;
      nocrs_tog_r <= 1'b0;
      tx_en_r <= 1'b0;
      txd_r <= 8'h00;
      done_r <= 1'b0;
      abort_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      abort_r <= 1'b0;
      case (st_r)
        ST_IDLE:
        begin
          if (tx_start_in)
          begin
            len_r <= tx_len_in;
            att_r <= 5'h00;
            rd_ptr_r <= '0;
            cnt_r <= 8'h00;
            st_r <= ST_DEFER;
          end
        end
        ST_DEFER:
        begin
          // R1: defer on carrier
          if (!dup_s && crs_s)
          begin
            cnt_r <= 8'h00;
          end
          else if (cnt_r == 8'(IFG_CYC - 1))
          begin
            // R2: enable with first byte
            st_r <= ST_XMIT;
            tx_en_r <= 1'b1;
            txd_r <= mem_r[rd_ptr_r];
            rd_ptr_r <= rd_ptr_r + 1'b1;
            cnt_r <= 8'h00;
            crs_seen_r <= 1'b0;
          end
          else
          begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        ST_XMIT:
        begin
          if (cnt_r != 8'(SLOT_CYC))
          begin
            cnt_r <= cnt_r + 8'h01;
            // R7: carrier expected within the slot
            if (crs_s)
            begin
              crs_seen_r <= 1'b1;
            end
          end
          // R3: collision cuts data, jam follows
          if (!dup_s && col_s)
          begin
            st_r <= ST_JAM;
            txd_r <= JAM_BYTE;
            cnt_r <= 8'h00;
          end
          else if (rd_ptr_r == len_r)
          begin
            st_r <= ST_IFG;
            tx_en_r <= 1'b0;
            cnt_r <= 8'h00;
          end
          else
          begin
            txd_r <= mem_r[rd_ptr_r];
            rd_ptr_r <= rd_ptr_r + 1'b1;
          end
        end
        ST_JAM:
        begin
          // R23: 32-bit jam
          if (cnt_r == 8'(JAM_CYC - 1))
          begin
            tx_en_r <= 1'b0;
            cnt_r <= 8'h00;
            if (att_r == MAX_ATTEMPTS - 5'h01)
            begin
              abort_r <= 1'b1;
              st_r <= ST_IDLE;
            end
            else
            begin
              // R4: truncated binary exponential backoff
              att_r <= att_r + 5'h01;
              bo_slots_r <= lfsr_r[9:0] & bo_mask(att_r + 5'h01);
              st_r <= ST_BACKOFF;
            end
          end
          else
          begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        ST_BACKOFF:
        begin
          if (bo_slots_r == 10'h000)
          begin
            // R5: replay from buffer start
            rd_ptr_r <= '0;
            cnt_r <= 8'h00;
            st_r <= ST_DEFER;
          end
          else if (cnt_r == 8'(SLOT_CYC - 1))
          begin
            cnt_r <= 8'h00;
            bo_slots_r <= bo_slots_r - 10'h001;
          end
          else
          begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        ST_IFG:
        begin
          // echo of a short frame lands in the gap; window stretched, accepted
          if (crs_s)
          begin
            crs_seen_r <= 1'b1;
          end
          // R6: gap before next frame
          if (cnt_r == 8'(IFG_CYC - 1))
          begin
            done_r <= 1'b1;
            st_r <= ST_IDLE;
            // R8: still a success, counted
            if (!dup_s && !crs_seen_r && !crs_s)
            begin
              nocrs_tog_r <= ~nocrs_tog_r;
            end
          end
          else
          begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        default:
        begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign tx_ready_out = (st_r == ST_IDLE);
  assign tx_en_out = tx_en_r;
  assign txd_out = txd_r;
  assign tx_done_out = done_r;
  assign tx_abort_out = abort_r;

  // ---------------- system domain ----------------
  logic [5:0] psy1_r, psy2_r;
  logic pl_s, fdx_s, antx_s, anrx_s;
  logic [1:0] spd_s;
  logic link_ok, link_ok_r, link_rise;
  logic [2:0] asd_sy_r, tog_sy_r;
  logic [7:0] asd_cnt_r;
  logic [1:0] asd_speed_r, mac_speed_r;
  logic asd_valid_r, irq_r, tfc_r, rfc_r;
  logic [7:0] sw_cnt_r;
  logic [31:0] nocrs_cnt_r;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      psy1_r <= 6'h00;
      psy2_r <= 6'h00;
      asd_sy_r <= 3'h0;
      tog_sy_r <= 3'h0;
    end
    else
    begin
      psy1_r <= {an_rx_pause_in, an_tx_pause_in, phy_speed_indication_in,
                 phy_full_duplex_indication_in, phy_link_in};
      psy2_r <= psy1_r;
      asd_sy_r <= {asd_sy_r[1:0], div_r[ASD_DIV_BIT]};
      tog_sy_r <= {tog_sy_r[1:0], nocrs_tog_r};
    end
  end
  assign pl_s = psy2_r[0];
  assign fdx_s = psy2_r[1];
  assign spd_s = psy2_r[3:2];
  assign antx_s = psy2_r[4];
  assign anrx_s = psy2_r[5];

  // R9: link ignored until enabled; R19: drop is link down
  assign link_ok = set_link_up_in & pl_s;
  assign link_rise = link_ok & ~link_ok_r;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      link_ok_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      link_ok_r <= link_ok;
      // R20: change interrupt
      irq_r <= link_change_int_en_in & (link_ok ^ link_ok_r);
    end
  end

  // R15: receive clock period measured in system cycles
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      asd_cnt_r <= 8'h00;
      asd_speed_r <= SPD_10;
      asd_valid_r <= 1'b0;
    end
    else if (asd_sy_r[2] ^ asd_sy_r[1])
    begin
      asd_cnt_r <= 8'h00;
      asd_valid_r <= 1'b1;
      if (asd_cnt_r <= ASD_FAST_MAX)
      begin
        asd_speed_r <= SPD_1000;
      end
      else if (asd_cnt_r <= ASD_MID_MAX)
      begin
        asd_speed_r <= SPD_100;
      end
      else
      begin
        asd_speed_r <= SPD_10;
      end
    end
    else if (asd_cnt_r != 8'hFF)
    begin
      asd_cnt_r <= asd_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mac_speed_r <= SPD_10;
      sw_cnt_r <= 8'h00;
    end
    else if (force_speed_in)
    begin
      // R11: forced speed overrides all
      if (speed_switch_bypass_in)
      begin
        // R12: bypass applies at once
        mac_speed_r <= speed_select_in;
        sw_cnt_r <= 8'h00;
      end
      else if (speed_select_in != mac_speed_r)
      begin
        // R12: clock switch delay
        if (sw_cnt_r == 8'(SPD_SWITCH_CYC - 1))
        begin
          mac_speed_r <= speed_select_in;
          sw_cnt_r <= 8'h00;
        end
        else
        begin
          sw_cnt_r <= sw_cnt_r + 8'h01;
        end
      end
      else
      begin
        sw_cnt_r <= 8'h00;
      end
    end
    else if (auto_speed_detect_enable_in)
    begin
      sw_cnt_r <= 8'h00;
      if (asd_valid_r && link_ok)
      begin
        mac_speed_r <= asd_speed_r;
      end
    end
    else
    begin
      sw_cnt_r <= 8'h00;
      // R13: reload at link-up
      if (link_rise)
      begin
        mac_speed_r <= spd_s;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      duplex_r <= 1'b0;
    end
    else if (force_duplex_in || force_duplex_alt_in)
    begin
      // R17: forced duplex
      duplex_r <= duplex_select_bit_in;
    end
    else if (link_rise)
    begin
      // R16: sample at good link
      duplex_r <= fdx_s;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tfc_r <= 1'b0;
      rfc_r <= 1'b0;
    end
    else if (!driver_loaded_in && autoneg_enable_in)
    begin
      // R10: flow bits from autoneg
      tfc_r <= antx_s;
      rfc_r <= anrx_s;
    end
    else
    begin
      tfc_r <= sw_tx_flow_in;
      rfc_r <= sw_rx_flow_in;
    end
  end

  // R8: count transmits without carrier
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      nocrs_cnt_r <= 32'h0000_0000;
    end
    else if (tog_sy_r[2] ^ tog_sy_r[1])
    begin
      nocrs_cnt_r <= nocrs_cnt_r + 32'h0000_0001;
    end
  end

  // R18: status mirrors gated phy link; R14: current speed
  assign link_up_status_out = link_ok_r;
  assign speed_status_out = mac_speed_r;
  assign duplex_status_bit_out = duplex_r;
  assign tx_flow_ctrl_enable_out = tfc_r;
  assign rx_flow_ctrl_enable_out = rfc_r;
  assign link_change_interrupt_out = irq_r;
  assign tx_no_crs_count_out = nocrs_cnt_r;

  chk_defer_carrier: assert property (@(posedge link_clk_in) disable iff (!nrst_in) // R1
    (st_r == ST_DEFER && !dup_s && crs_s) |=> st_r != ST_XMIT)
    else $error("frame started while carrier present");
  chk_txen_frame: assert property (@(posedge link_clk_in) disable iff (!nrst_in) // R2
    $rose(st_r == ST_XMIT) |-> tx_en_out && $past(st_r) == ST_DEFER)
    else $error("transmit enable missing at frame start");
  chk_col_stop: assert property (@(posedge link_clk_in) disable iff (!nrst_in) // R3
    (st_r == ST_XMIT && !dup_s && $rose(col_in)) |-> ##[1:4] st_r != ST_XMIT)
    else $error("collision did not stop data in four clocks");
  chk_jam_length: assert property (@(posedge link_clk_in) disable iff (!nrst_in) // R23
    $rose(st_r == ST_JAM) |-> (st_r == ST_JAM && txd_out == JAM_BYTE)[*4] ##1 st_r != ST_JAM)
    else $error("jam not 32 bits");
  chk_backoff_follow: assert property (@(posedge link_clk_in) disable iff (!nrst_in) // R4
    $fell(st_r == ST_JAM) |-> (st_r == ST_BACKOFF && att_r == $past(att_r) + 5'h01)
      || (st_r == ST_IDLE && tx_abort_out))
    else $error("no backoff after jam");
  chk_retry_replay: assert property (@(posedge link_clk_in) disable iff (!nrst_in) // R5
    (st_r == ST_BACKOFF && bo_slots_r == 10'h000) |=> st_r == ST_DEFER && rd_ptr_r == '0)
    else $error("retry does not restart buffer");
  chk_ifg_gap: assert property (@(posedge link_clk_in) disable iff (!nrst_in) // R6
    $rose(st_r == ST_IFG) |-> (!tx_en_out && !tx_ready_out)[*8])
    else $error("next frame before gap");
  chk_nocrs_count: assert property (@(posedge clk_in) disable iff (!nrst_in) // R8
    (tog_sy_r[2] ^ tog_sy_r[1]) |=> tx_no_crs_count_out == $past(tx_no_crs_count_out) + 32'h1)
    else $error("no-carrier counter missed");
  chk_link_gate: assert property (@(posedge clk_in) disable iff (!nrst_in) // R9
    !set_link_up_in |=> !link_up_status_out)
    else $error("link up without set-link-up");
  chk_force_speed: assert property (@(posedge clk_in) disable iff (!nrst_in) // R11
    (force_speed_in && speed_switch_bypass_in) |=> speed_status_out == $past(speed_select_in))
    else $error("forced bypass speed not applied");
  chk_force_duplex: assert property (@(posedge clk_in) disable iff (!nrst_in) // R17
    force_duplex_in |=> duplex_status_bit_out == $past(duplex_select_bit_in))
    else $error("forced duplex not applied");
  chk_link_irq: assert property (@(posedge clk_in) disable iff (!nrst_in) // R20
    (link_change_int_en_in && !link_ok && link_ok_r) |=> link_change_interrupt_out)
    else $error("link drop raised no interrupt");

endmodule

// [test/mhd_phy_model.sv]
`timescale 1ns/1ps
module mhd_phy_model (
  input wire logic link_clk_in, // link clock
  input wire logic nrst_in, // reset, active low
  input wire logic tx_en_in, // mac transmit enable
  input wire logic echo_in, // return carrier while mac sends
  input wire logic busy_in, // foreign traffic on the wire
  input wire logic col_arm_in, // collide once on next frame
  output logic crs_out, // carrier sense
  output logic col_out // collision
);
  logic [1:0] en_d_r;
  logic [3:0] run_r;
  logic fired_r;
  always_ff @(posedge link_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      en_d_r <= 2'h0;
      run_r <= 4'h0;
      fired_r <= 1'b0;
    end
    else
    begin
      en_d_r <= {en_d_r[0], tx_en_in};
      run_r <= tx_en_in ? run_r + 4'h1 : 4'h0;
      fired_r <= col_arm_in & (fired_r | col_out);
    end
  end
  // carrier returned two clocks into the frame
  assign crs_out = busy_in | (echo_in & en_d_r[1]);
  // one collision per arming, so the retry can finish
  assign col_out = col_arm_in & ~fired_r & tx_en_in & (run_r >= 4'h3);
endmodule

// [test/mhd_top_tb.sv]
`timescale 1ns/1ps
module mhd_top_tb;
  import mhd_pkg::*;
  logic clk_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic nrst_in, buf_wr_en_in, tx_start_in, crs_in, col_in, phy_link_in;
  logic phy_full_duplex_indication_in, an_tx_pause_in, an_rx_pause_in, set_link_up_in;
  logic force_speed_in, speed_switch_bypass_in, auto_speed_detect_enable_in, force_duplex_in;
  logic force_duplex_alt_in, duplex_select_bit_in, link_change_int_en_in, driver_loaded_in;
  logic autoneg_enable_in, sw_tx_flow_in, sw_rx_flow_in, tx_ready_out, tx_done_out;
  logic tx_abort_out, tx_en_out, link_up_status_out, duplex_status_bit_out;
  logic tx_flow_ctrl_enable_out, rx_flow_ctrl_enable_out, link_change_interrupt_out;
  logic echo, busy, col_arm, colb;
  logic [1:0] phy_speed_indication_in, speed_select_in, speed_status_out;
  logic [BUF_AW-1:0] buf_wr_addr_in, tx_len_in;
  logic [7:0] buf_wr_data_in, txd_out;
  logic [7:0] mem [0:31];
  logic [7:0] exp_q[$];
  logic [7:0] bq[$];
  logic [31:0] tx_no_crs_count_out, c0;
  int err_total, cmp_count, irq_cnt, done_cnt, cyc_cnt, gap, ccol, jidx, r0;

  mhd_top DUT (.clk_in, .nrst_in, .link_clk_in, .buf_wr_en_in, .buf_wr_addr_in,
    .buf_wr_data_in, .tx_len_in, .tx_start_in, .tx_ready_out, .tx_done_out, .tx_abort_out,
    .txd_out, .tx_en_out, .crs_in, .col_in, .phy_link_in, .phy_full_duplex_indication_in,
    .phy_speed_indication_in, .an_tx_pause_in, .an_rx_pause_in, .set_link_up_in,
    .force_speed_in, .speed_select_in, .speed_switch_bypass_in, .auto_speed_detect_enable_in,
    .force_duplex_in, .force_duplex_alt_in, .duplex_select_bit_in, .link_change_int_en_in,
    .driver_loaded_in, .autoneg_enable_in, .sw_tx_flow_in, .sw_rx_flow_in,
    .link_up_status_out, .speed_status_out, .duplex_status_bit_out, .tx_flow_ctrl_enable_out,
    .rx_flow_ctrl_enable_out, .link_change_interrupt_out, .tx_no_crs_count_out);

  mhd_phy_model PHY (.link_clk_in, .nrst_in, .tx_en_in(tx_en_out), .echo_in(echo),
    .busy_in(busy), .col_arm_in(col_arm), .crs_out(crs_in), .col_out(col_in));

  always #10 clk_in = ~clk_in;
  // offset keeps the link edges off the system edges
  initial
  begin
    #3;
    forever #6 link_clk_in = ~link_clk_in;
  end

  task finish_test;
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task relink;
    phy_link_in = 1'b0;
    cyc(8);
    chk(link_up_status_out, 0);
    phy_link_in = 1'b1;
    cyc(8);
  endtask

  task load(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge link_clk_in);
      buf_wr_en_in = 1'b1;
      buf_wr_addr_in = i[BUF_AW-1:0];
      // bit 0 cleared so data never looks like jam
      buf_wr_data_in = 8'($urandom) & 8'hFE;
      mem[i] = buf_wr_data_in;
    end
    @(negedge link_clk_in);
    buf_wr_en_in = 1'b0;
  endtask

  task start(input int n);
    for (int k = 0; k < 3000 && tx_ready_out !== 1'b1; k++)
      @(negedge link_clk_in);
    tx_len_in = n[BUF_AW-1:0];
    tx_start_in = 1'b1;
    for (int i = 0; i < n; i++)
      exp_q.push_back(mem[i]);
    @(negedge link_clk_in);
    tx_start_in = 1'b0;
  endtask

  task wait_done;
    r0 = done_cnt;
    for (int k = 0; k < 3000 && done_cnt == r0; k++)
      @(negedge link_clk_in);
    chk(done_cnt, r0 + 1);
  endtask

  // frame watcher: compares bytes against the notes left by the driver
  always @(posedge link_clk_in)
  begin
    if (tx_done_out === 1'b1)
      done_cnt++;
    if (tx_en_out === 1'b1)
    begin
      if (bq.size() == 0)
        chk(gap >= IFG_CYC, 1);
      if (col_in === 1'b1 && !colb)
      begin
        colb = 1'b1;
        ccol = bq.size();
      end
      bq.push_back(txd_out);
      gap = 0;
    end
    else
    begin
      gap++;
      if (bq.size() > 0 && colb)
      begin
        jidx = ccol;
        while (jidx < bq.size() && bq[jidx] !== JAM_BYTE)
          jidx++;
        chk(jidx - ccol <= 4, 1);
        chk(bq.size() - jidx, JAM_CYC);
        chk(tx_abort_out, 0);
      end
      else
        foreach (bq[i])
          chk(bq[i], exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
      bq.delete();
      colb = 1'b0;
    end
  end

  always @(posedge clk_in)
  begin
    if (link_change_interrupt_out === 1'b1)
      irq_cnt++;
    cyc_cnt++;
    if (cyc_cnt == 60000)
    begin
      err_total++;
      finish_test;
    end
  end

  initial
  begin
    {nrst_in, buf_wr_en_in, tx_start_in, phy_link_in, an_tx_pause_in} = '0;
    {phy_full_duplex_indication_in, an_rx_pause_in, set_link_up_in, force_speed_in} = '0;
    {speed_switch_bypass_in, auto_speed_detect_enable_in, force_duplex_in} = '0;
    {force_duplex_alt_in, duplex_select_bit_in, driver_loaded_in, sw_tx_flow_in} = '0;
    {sw_rx_flow_in, echo, busy, col_arm, colb, phy_speed_indication_in, speed_select_in} = '0;
    {buf_wr_addr_in, buf_wr_data_in, tx_len_in} = '0;
    {link_change_int_en_in, autoneg_enable_in} = 2'h3;
    gap = IFG_CYC;
    r0 = $urandom(82101);
    cyc(10);
    nrst_in = 1'b1;
    phy_link_in = 1'b1;
    cyc(8);
    chk(link_up_status_out, 0);
    r0 = irq_cnt;
    set_link_up_in = 1'b1;
    cyc(8);
    chk(link_up_status_out, 1);
    chk(irq_cnt, r0 + 1);
    for (int i = 0; i < 3; i++)
    begin
      phy_speed_indication_in = 2'((i + 2) % 3);
      phy_full_duplex_indication_in = i[0];
      relink;
      chk(irq_cnt, r0 + 3);
      link_change_int_en_in = 1'b0;
      chk(speed_status_out, (i + 2) % 3);
      chk(duplex_status_bit_out, i[0]);
    end
    chk(irq_cnt, r0 + 3);
    for (int i = 1; i < 8; i++)
    begin
      {force_duplex_in, force_duplex_alt_in, duplex_select_bit_in} = 3'(i);
      cyc(4);
      chk(duplex_status_bit_out, i > 1 ? i[0] : 1'b0);
    end
    {force_duplex_in, force_duplex_alt_in} = 2'h0;
    // pause results with and without a driver
    for (int i = 0; i < 16; i++)
    begin
      {autoneg_enable_in, driver_loaded_in, an_tx_pause_in, an_rx_pause_in} = 4'(i ^ 8);
      {sw_tx_flow_in, sw_rx_flow_in} = 2'($urandom);
      cyc(6);
      chk({tx_flow_ctrl_enable_out, rx_flow_ctrl_enable_out},
        i[2] | i[3] ? {sw_tx_flow_in, sw_rx_flow_in} : i[1:0]);
    end
    {force_speed_in, speed_switch_bypass_in, speed_select_in} = {2'h3, SPD_10};
    cyc(3);
    chk(speed_status_out, SPD_10);
    {speed_switch_bypass_in, speed_select_in} = {1'b0, SPD_1000};
    cyc(10);
    chk(speed_status_out, SPD_10);
    cyc(SPD_SWITCH_CYC + 10);
    chk(speed_status_out, SPD_1000);
    relink;
    chk(speed_status_out, SPD_1000);
    force_speed_in = 1'b0;
    relink;
    chk(speed_status_out, SPD_100);
    auto_speed_detect_enable_in = 1'b1;
    cyc(300);
    chk(speed_status_out, SPD_1000);
    auto_speed_detect_enable_in = 1'b0;
    relink;
    chk(speed_status_out, SPD_100);
    for (int i = 0; i < 4; i++)
    begin
      echo = i[0];
      r0 = i == 3 ? 1 : 4 + $urandom % 20;
      load(r0);
      c0 = tx_no_crs_count_out;
      start(r0);
      wait_done;
      cyc(4);
      chk(tx_no_crs_count_out, c0 + !echo);
    end
    load(16);
    r0 = done_cnt;
    busy = 1'b1;
    start(16);
    repeat (100) @(negedge link_clk_in);
    chk(tx_en_out, 0);
    busy = 1'b0;
    wait_done;
    echo = 1'b1;
    col_arm = 1'b1;
    start(16);
    wait_done;
    col_arm = 1'b0;
    start(16);
    start(16);
    wait_done;
    cyc(20);
    chk(exp_q.size(), 0);
    finish_test;
  end
endmodule
